// [action_command_filter.sv]
// The Wishbone interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
module action_command_filter
   import action_filter_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADDR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic msg_valid,
   input wire action_msg_t msg,
   output logic [NUM_ACTIONS-1:0] action_pulse,
   output logic frame_begin_trigger
);

   // ==========================================================
   // Helpers
   // Settings and bus answer are computed here and registered below;
   // the bus side writes the settings, the message side only reads them.
   // Byte-lane merge: only lanes whose select bit is set take new data,
   // so a narrow write never disturbs the neighbouring bytes
   function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
      input logic [31:0] new_v, input logic [3:0] sel);
      logic [31:0] r;
      r = old_v;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            r[8*b +: 8] = new_v[8*b +: 8];
         end
      end
      return r;
   endfunction

   // Index 1 maps to slot 0; zero or out of range selects nothing
   // Zero is reserved because action indices count from one
   function automatic logic sel_ok(input logic [SEL_W-1:0] s);
      return (s != 3'h0) && (s <= SEL_W'(NUM_ACTIONS));
   endfunction

   // Slot number of a select; only meaningful once sel_ok has passed
   function automatic logic [1:0] sel_slot(input logic [SEL_W-1:0] s);
      logic [SEL_W-1:0] t;
      t = s - 3'h1;
      return t[1:0];
   endfunction

   // Group checks of one slot; a zero mask on either side never matches,
   // which keeps a freshly reset slot silent
   function automatic logic slot_hit(input logic dev_ok,
      input action_msg_t m, input logic [KEY_W-1:0] gk,
      input logic [KEY_W-1:0] gm);
      logic mask_ok;
      logic key_ok;
      mask_ok = (m.group_mask & gm) != '0;
      key_ok = m.group_key == gk;
      return dev_ok && mask_ok && key_ok;
   endfunction

   // ==========================================================
   // Register state
   // Word map seen by software:
   //   device filter key at OFS_DEVICE_KEY, write-only, reads as zero
   //   action index select at OFS_SELECT, one up to the slot count
   //   group filter key of the selected slot at OFS_GROUP_KEY
   //   group filter mask of the selected slot at OFS_GROUP_MASK
   // Slots are plain arrays; the select register picks one for the bus
   // and the message side reads all of them at once.
   logic [KEY_W-1:0] device_filter_key, next_device_filter_key;
   logic [SEL_W-1:0] action_index_select, next_action_index_select;
   logic [KEY_W-1:0] group_filter_key [NUM_ACTIONS];
   logic [KEY_W-1:0] group_filter_mask [NUM_ACTIONS];
   logic [KEY_W-1:0] next_group_filter_key [NUM_ACTIONS];
   logic [KEY_W-1:0] next_group_filter_mask [NUM_ACTIONS];
   // Bus answer, registered so ack and data leave straight from flops
   logic [31:0] next_wb_dat_o;
   logic next_wb_ack_o;
   logic req;

   // Ack one cycle after request, dropped the next so no double write
   // Requests are taken only while ack is low, so a strobe held through
   // the ack cycle never lands twice
   assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;

   // Bus decode and register next values
   // Read data is captured with the ack so it stands while ack stands
   always_comb begin
      next_device_filter_key = device_filter_key;
      next_action_index_select = action_index_select;
      next_group_filter_key = group_filter_key;
      next_group_filter_mask = group_filter_mask;
      next_wb_ack_o = req;
      next_wb_dat_o = 32'h0000_0000;
      if (req && wb_we_i) begin
         // Writes to unmapped offsets fall through and are dropped
         case (wb_adr_i)
            OFS_DEVICE_KEY: next_device_filter_key =
               merge_bytes(device_filter_key, wb_dat_i, wb_sel_i);
            OFS_SELECT: begin
               // The select field sits in the low byte lane
               if (wb_sel_i[0]) begin
                  next_action_index_select = wb_dat_i[SEL_W-1:0];
               end
            end
            // Group writes reach the selected slot only, if it exists
            OFS_GROUP_KEY: begin
               if (sel_ok(action_index_select)) begin
                  next_group_filter_key[sel_slot(action_index_select)] =
                     merge_bytes(group_filter_key[
                     sel_slot(action_index_select)], wb_dat_i,
                     wb_sel_i);
               end
            end
            OFS_GROUP_MASK: begin
               if (sel_ok(action_index_select)) begin
                  next_group_filter_mask[sel_slot(action_index_select)] =
                     merge_bytes(group_filter_mask[
                     sel_slot(action_index_select)], wb_dat_i,
                     wb_sel_i);
               end
            end
            default: ;
         endcase
      end else if (req) begin
         // Device key is write-only so it reads as zero
         // A parked select reads zero from both group registers
         case (wb_adr_i)
            OFS_SELECT: next_wb_dat_o = {29'h0, action_index_select};
            OFS_GROUP_KEY: begin
               if (sel_ok(action_index_select)) begin
                  next_wb_dat_o =
                     group_filter_key[sel_slot(action_index_select)];
               end
            end
            OFS_GROUP_MASK: begin
               if (sel_ok(action_index_select)) begin
                  next_wb_dat_o =
                     group_filter_mask[sel_slot(action_index_select)];
               end
            end
            default: next_wb_dat_o = 32'h0000_0000;
         endcase
      end
   end

   // Register bank; reset clears every mask, so no slot can match
   // until software has configured it
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         device_filter_key <= RST_KEY;
         action_index_select <= RST_SELECT;
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
         for (int i = 0; i < NUM_ACTIONS; i++) begin
            group_filter_key[i] <= RST_KEY;
            group_filter_mask[i] <= RST_MASK;
         end
      end else begin
         device_filter_key <= next_device_filter_key;
         action_index_select <= next_action_index_select;
         wb_ack_o <= next_wb_ack_o;
         wb_dat_o <= next_wb_dat_o;
         group_filter_key <= next_group_filter_key;
         group_filter_mask <= next_group_filter_mask;
      end
   end

   // ==========================================================
   // Message matching, all slots in parallel
   // Matching reads the registered settings, so a write landing in the
   // same cycle as a message only affects the messages after it.
   logic [NUM_ACTIONS-1:0] hit, next_action_pulse;
   logic dev_match;
   logic next_frame_begin_trigger;

   // Device key is shared, so it is compared once for all slots
   assign dev_match = msg.device_key == device_filter_key;

   // Bit g of hit is action index g+1
   // Each slot decides on its own; several may fire for one message
   generate
      for (genvar g = 0; g < NUM_ACTIONS; g++) begin : g_match
         assign hit[g] = slot_hit(dev_match, msg, group_filter_key[g],
            group_filter_mask[g]);
      end
   endgenerate

   // Pulse only in the cycle after an accepted message; a broadcast
   // that fails the device check or every slot's group check leaves every line low
   always_comb begin
      next_action_pulse = msg_valid ? hit : '0;
      next_frame_begin_trigger = msg_valid && hit[0];
   end

   // Pulses register so outputs come straight from flops
   // Both are registered so a consumer sees a clean one-cycle pulse
   // Action index one doubles as the frame-start trigger; the other
   // indices reach their consumers through action_pulse alone
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         action_pulse <= '0;
         frame_begin_trigger <= 1'b0;
      end else begin
         action_pulse <= next_action_pulse;
         frame_begin_trigger <= next_frame_begin_trigger;
      end
   end

endmodule

// [action_command_filter_sva.sv]
`timescale 1ns/1ns
module acf_checker import action_filter_pkg::*; (
   input wire logic clk,
   input wire logic rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic wb_ack_o,
   input wire logic [ADDR_W-1:0] wb_adr_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic msg_valid,
   input wire logic frame_begin_trigger,
   input wire action_msg_t msg,
   input wire logic [NUM_ACTIONS-1:0] action_pulse
);
   // ====
   // Bus and trigger timing, all on the one clock
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
   a_ack: assert property (p_ack) else $error("request not acked");
   property p_ack_one; wb_ack_o |=> !wb_ack_o; endproperty
   a_ack_one: assert property (p_ack_one) else $error("ack too long");
   property p_no_spur; $rose(wb_ack_o) |-> $past(wb_stb_i); endproperty
   a_no_spur: assert property (p_no_spur) else $error("stray ack");
   // Pulses only follow a message strobe; checks the strobe only, not the key and mask match
   property p_src; action_pulse != '0 |-> $past(msg_valid); endproperty
   a_src: assert property (p_src) else $error("pulse without message");
   property p_trig; frame_begin_trigger == action_pulse[0]; endproperty
   a_trig: assert property (p_trig) else $error("trigger mismatch");
   property p_mask; msg_valid && msg.group_mask == '0 |=> action_pulse == '0;
   endproperty
   a_mask: assert property (p_mask) else $error("zero mask fired");
   // Device key is write-only, so it must read as zero
   property p_dkey; wb_ack_o && !$past(wb_we_i)
      && $past(wb_adr_i) == OFS_DEVICE_KEY |-> wb_dat_o == '0; endproperty
   a_dkey: assert property (p_dkey) else $error("device key readable");
   property p_sel; wb_ack_o && !$past(wb_we_i)
      && $past(wb_adr_i) == OFS_SELECT |-> wb_dat_o[31:SEL_W] == '0;
   endproperty
   a_sel: assert property (p_sel) else $error("select too wide");
endmodule
bind action_command_filter acf_checker u_chk (
   .clk(clk),
   .rst(rst),
   .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i),
   .wb_ack_o(wb_ack_o),
   .wb_adr_i(wb_adr_i),
   .wb_dat_o(wb_dat_o),
   .msg_valid(msg_valid),
   .frame_begin_trigger(frame_begin_trigger),
   .msg(msg),
   .action_pulse(action_pulse)
);

// [action_filter_pkg.sv]
package action_filter_pkg;

   // ==========================================================
   // Sizes
   localparam int KEY_W = 32;
   localparam int NUM_ACTIONS = 4;
   localparam int SEL_W = 3;
   localparam int ADDR_W = 4;

   // ==========================================================
   // Register byte offsets
   localparam logic [ADDR_W-1:0] OFS_DEVICE_KEY = 4'h0;
   localparam logic [ADDR_W-1:0] OFS_SELECT = 4'h4;
   localparam logic [ADDR_W-1:0] OFS_GROUP_KEY = 4'h8;
   localparam logic [ADDR_W-1:0] OFS_GROUP_MASK = 4'hC;

   // ==========================================================
   // Reset values
   localparam logic [KEY_W-1:0] RST_KEY = 32'h0000_0000;
   localparam logic [SEL_W-1:0] RST_SELECT = 3'h1;
   localparam logic [KEY_W-1:0] RST_MASK = 32'h0000_0000;

   // Decoded broadcast action message from the transport receiver
   typedef struct packed {
      logic [KEY_W-1:0] device_key;
      logic [KEY_W-1:0] group_key;
      logic [KEY_W-1:0] group_mask;
   } action_msg_t;

endpackage

// [msg_source.sv]
`timescale 1ns/1ns
module msg_source import action_filter_pkg::*; (
   input wire logic clk,
   output logic msg_valid,
   output action_msg_t msg
);
   // ====
   // Transport receiver: one decoded broadcast message per call
   initial begin
      msg_valid = 1'b0;
      msg = '0;
   end
   // Fields invert after the strobe so stale data never looks current
   task automatic send(input action_msg_t m);
      @(posedge clk);
      msg_valid <= 1'b1;
      msg <= m;
      @(posedge clk);
      msg_valid <= 1'b0;
      msg <= ~m;
   endtask
endmodule

// [tb_action_command_filter.sv]
`timescale 1ns/1ns
module tb_action_command_filter import action_filter_pkg::*;;
   logic clk, rst, cyc, stb, we, ack, valid, trig;
   logic [3:0] adr, sel, pulse;
   logic [31:0] wdat, rdat, q;
   action_msg_t msg;
   int miscompares, comparisons;
   action_msg_t m [5] = '{'{32'h1234_5678, 32'h77, 32'h5},
      '{32'h1234_5678, 32'h77, 32'h0}, '{32'h1234_5678, 32'h78, 32'hF},
      '{32'h1234_5679, 32'h77, 32'hF}, '{32'h1234_5678, 32'h77, 32'h8}};
   logic [3:0] e [5] = '{4'h5, 4'h0, 4'h0, 4'h0, 4'h8};
   action_command_filter u_dut (.clk(clk), .rst(rst), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
      .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .msg_valid(valid),
      .msg(msg), .action_pulse(pulse), .frame_begin_trigger(trig));
   msg_source u_src (.clk(clk), .msg_valid(valid), .msg(msg));
   // ====
   // Helpers
   task chk(input logic [31:0] s, input logic [31:0] x);
      comparisons++;
      if (s !== x) begin
         miscompares++;
         $display("[FAIL] %0t seen %h exp %h", $time, s, x);
      end
   endtask
   // Classic single cycle; waits for ack, the watchdog bounds it
   task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
      do @(posedge clk); while (ack !== 1'b1);
      q = rdat;
      {cyc, stb} <= 2'b00;
   endtask
   task t_regs;
      wb(1'b0, OFS_SELECT, 32'h0);
      chk(q, 32'(RST_SELECT));
      wb(1'b1, OFS_DEVICE_KEY, 32'h1234_5678);
      wb(1'b0, OFS_DEVICE_KEY, 32'h0);
      chk(q, 32'h0);
      wb(1'b1, OFS_SELECT, 32'h0);
      wb(1'b1, OFS_GROUP_KEY, 32'hFFFF_FFFF);
      wb(1'b0, OFS_GROUP_KEY, 32'h0);
      chk(q, 32'h0);
      wb(1'b0, 4'h2, 32'h0);
      chk(q, 32'h0);
      for (int i = 1; i <= NUM_ACTIONS; i++) begin
         wb(1'b1, OFS_SELECT, 32'(i));
         wb(1'b1, OFS_GROUP_KEY, 32'h77);
         wb(1'b1, OFS_GROUP_MASK, 32'h1 << (i - 1));
      end
      // Read back after all writes to prove each index is separate
      for (int i = 1; i <= NUM_ACTIONS; i++) begin
         wb(1'b1, OFS_SELECT, 32'(i));
         wb(1'b0, OFS_GROUP_MASK, 32'h0);
         chk(q, 32'h1 << (i - 1));
         wb(1'b0, OFS_GROUP_KEY, 32'h0);
         chk(q, 32'h77);
      end
      // A select past the last slot reads back but touches no slot
      wb(1'b1, OFS_SELECT, 32'h5);
      wb(1'b0, OFS_SELECT, 32'h0);
      chk(q, 32'h5);
      wb(1'b1, OFS_GROUP_MASK, 32'hFFFF_FFFF);
      wb(1'b0, OFS_GROUP_MASK, 32'h0);
      chk(q, 32'h0);
      // Lane one only: slot one's mask must keep its low byte
      wb(1'b1, OFS_SELECT, 32'h1);
      sel <= 4'h2;
      wb(1'b1, OFS_GROUP_MASK, 32'hFFFF_FF00);
      sel <= 4'hF;
      wb(1'b0, OFS_GROUP_MASK, 32'h0);
      chk(q, 32'h0000_FF01);
      $display("t_regs done");
   endtask
   task t_match;
      for (int i = 0; i < 5; i++) begin
         u_src.send(m[i]);
         #1;
         chk(32'(pulse), 32'(e[i]));
         chk(32'(trig), 32'(e[i][0]));
         @(posedge clk);
         #1;
         chk(32'(pulse), 32'h0);
      end
      $display("t_match done");
   endtask
   task stop_test;
      $display("miscompares %0d comparisons %0d", miscompares, comparisons);
      if (miscompares == 0 && comparisons > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // Run takes about 150 cycles; the watchdog allows far more
   initial begin
      #200000;
      miscompares++;
      stop_test;
   end
   initial begin
      {rst, cyc, stb, we, adr, sel, wdat} = {4'h8, 4'h0, 4'hF, 32'h0};
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      t_regs;
      t_match;
      stop_test;
   end
endmodule
